// ### rtl/defective_pixel_corrector.v
// Table based defective pixel corrector with staging, active and persistent
// tables, a five pixel correction window and an output FIFO.
// Assumes pixel stream and register port are synchronous to ref_clk.
//
// Operation
// [RQ1] Enable off passes pixels unchanged
// [RQ2] Average mode outputs mean of neighbours
// [RQ3] Highlight mode outputs full scale value
// [RQ4] Count sets table size, growth appends
// [RQ5] Selector is zero based, below count
// [RQ6] X and Y of selected entry writable
// [RQ7] Coordinates refer to full sensor frame
// [RQ8] Edits touch staging only until apply
// [RQ9] Apply copies staging into volatile active
// [RQ10] Save persists table, loaded at boot
// [RQ11] Save overwrites earlier persistent table
// [RQ12] Factory restore replaces active and persistent
// [RQ13] Ships with calibrated default list
// [RQ14] Frames may glitch during table load
// [RQ15] Zero mode forces listed pixels to zero
// [RQ16] Neighbours are same colour horizontal pixels
// [RQ17] Selected entry coordinates read back
`timescale 1ns/1ns
`default_nettype none
`include "dpc_regs.vh"

// =====================================================================
// Output FIFO with registered head
module pix_fifo #(
  parameter W     = 14,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  // Clock and reset
  input  wire          clk,
  input  wire          rst,
  // Fill side
  input  wire          in_valid,
  output wire          in_ready,
  input  wire [W-1:0]  in_data,
  output wire [AW:0]   level,
  // Drain side
  output wire          out_valid,
  input  wire          out_ready,
  output wire [W-1:0]  out_data
);
  reg [W-1:0]  mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_ff;
  reg [AW-1:0] rd_ptr_ff;
  reg [AW:0]   cnt_ff;
  reg          head_vld_ff;
  reg [W-1:0]  head_ff;
  wire         push;
  wire         pop;

  assign in_ready  = (cnt_ff != DEPTH[AW:0]);
  assign push      = in_valid & in_ready;
  assign pop       = (cnt_ff != {(AW+1){1'b0}}) & (~head_vld_ff | out_ready);
  assign level     = cnt_ff;
  assign out_valid = head_vld_ff;
  assign out_data  = head_ff;

  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_ff] <= in_data;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      wr_ptr_ff   <= {AW{1'b0}};
      rd_ptr_ff   <= {AW{1'b0}};
      cnt_ff      <= {(AW+1){1'b0}};
      head_vld_ff <= 1'b0;
      head_ff     <= {W{1'b0}};
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
        head_ff   <= mem[rd_ptr_ff];
      end
      if (pop) begin
        head_vld_ff <= 1'b1;
      end else if (out_ready) begin
        head_vld_ff <= 1'b0;
      end
      if (push & ~pop) begin
        cnt_ff <= cnt_ff + 1'b1;
      end else if (pop & ~push) begin
        cnt_ff <= cnt_ff - 1'b1;
      end
    end
  end
endmodule

// =====================================================================
// Corrector top
module defective_pixel_corrector (
  // Clock and reset
  input  wire        ref_clk,
  input  wire        rst,
  // Register port
  input  wire [7:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  // Window offsets of the current readout
  input  wire [11:0] roi_off_x,
  input  wire [11:0] roi_off_y,
  // Pixel input stream
  input  wire        pix_valid,
  output reg         pix_ready,
  input  wire [11:0] pix_data,
  input  wire        pix_sof,
  input  wire        pix_eol,
  // Corrected output stream
  output wire        out_valid,
  input  wire        out_ready,
  output wire [11:0] out_data,
  output wire        out_sof,
  output wire        out_eol
);
  localparam [4:0] S_IDLE  = 5'h01;
  localparam [4:0] S_APPLY = 5'h02;
  localparam [4:0] S_SAVE  = 5'h04;
  localparam [4:0] S_FACT  = 5'h08;
  localparam [4:0] S_BOOT  = 5'h10;

  // Arbitrary default defect list, stands for calibration data
  function [23:0] factory_xy;
    input [3:0] i;
    begin
      case (i)
        4'h0:    factory_xy = {12'h0064, 12'h0032};
        4'h1:    factory_xy = {12'h0200, 12'h0101};
        4'h2:    factory_xy = {12'h0400, 12'h02BC};
        4'h3:    factory_xy = {12'h0007, 12'h0005};
        default: factory_xy = {12'h0000, 12'h0000};
      endcase
    end
  endfunction

  function [4:0] clamp_cnt;
    input [31:0] v;
    begin
      if (v > `DPC_ENTRIES) begin
        clamp_cnt = 5'h10;
      end else begin
        clamp_cnt = v[4:0];
      end
    end
  endfunction

  // =====================================================================
  // Table storage
  reg [11:0] stg_x [0:15];
  reg [11:0] stg_y [0:15];
  reg [11:0] act_x [0:15];
  reg [11:0] act_y [0:15];
  reg [11:0] nvm_x [0:15];
  reg [11:0] nvm_y [0:15];
  reg [4:0]  nvm_cnt_ff;
  reg [15:0] nvm_mark_ff;

  reg [4:0]  state_ff;
  reg [3:0]  cp_idx_ff;
  reg        fix_on_ff;
  reg [1:0]  method_ff;
  reg [4:0]  stg_cnt_ff;
  reg [4:0]  act_cnt_ff;
  reg [3:0]  sel_ff;
  reg [31:0] rdata_ff;

  wire       idle     = (state_ff == S_IDLE);
  wire       boot_nvm = (nvm_mark_ff == `DPC_NVM_MARK);
  wire       last     = (cp_idx_ff == `DPC_LAST_IDX);
  wire [23:0] fxy     = factory_xy(cp_idx_ff);
  wire       wr_x     = idle & reg_wr & (reg_addr == `DPC_A_COORD_X);
  wire       wr_y     = idle & reg_wr & (reg_addr == `DPC_A_COORD_Y);

  // Table copies; persistent copy has no reset so it outlives rst
  always @(posedge ref_clk) begin
    case (state_ff)
      S_APPLY: begin
        act_x[cp_idx_ff] <= stg_x[cp_idx_ff]; // RQ9
        act_y[cp_idx_ff] <= stg_y[cp_idx_ff]; // RQ9
      end
      S_SAVE: begin
        nvm_x[cp_idx_ff] <= stg_x[cp_idx_ff]; // RQ11
        nvm_y[cp_idx_ff] <= stg_y[cp_idx_ff]; // RQ11
        if (last) begin
          nvm_cnt_ff  <= stg_cnt_ff; // RQ10
          nvm_mark_ff <= `DPC_NVM_MARK;
        end
      end
      S_FACT: begin
        stg_x[cp_idx_ff] <= fxy[23:12]; // RQ12
        stg_y[cp_idx_ff] <= fxy[11:0];
        act_x[cp_idx_ff] <= fxy[23:12]; // RQ12
        act_y[cp_idx_ff] <= fxy[11:0];
        nvm_x[cp_idx_ff] <= fxy[23:12]; // RQ12
        nvm_y[cp_idx_ff] <= fxy[11:0];
        if (last) begin
          nvm_cnt_ff  <= `DPC_FACT_CNT;
          nvm_mark_ff <= `DPC_NVM_MARK;
        end
      end
      S_BOOT: begin
        if (boot_nvm) begin
          act_x[cp_idx_ff] <= nvm_x[cp_idx_ff]; // RQ10
          act_y[cp_idx_ff] <= nvm_y[cp_idx_ff];
          stg_x[cp_idx_ff] <= nvm_x[cp_idx_ff];
          stg_y[cp_idx_ff] <= nvm_y[cp_idx_ff];
        end else begin
          act_x[cp_idx_ff] <= fxy[23:12]; // RQ13
          act_y[cp_idx_ff] <= fxy[11:0];
          stg_x[cp_idx_ff] <= fxy[23:12];
          stg_y[cp_idx_ff] <= fxy[11:0];
          nvm_x[cp_idx_ff] <= fxy[23:12];
          nvm_y[cp_idx_ff] <= fxy[11:0];
          if (last) begin
            nvm_cnt_ff  <= `DPC_FACT_CNT;
            nvm_mark_ff <= `DPC_NVM_MARK;
          end
        end
      end
      default: begin
        if (wr_x) begin
          stg_x[sel_ff] <= reg_wdata[11:0]; // RQ6 RQ8
        end
        if (wr_y) begin
          stg_y[sel_ff] <= reg_wdata[11:0]; // RQ6 RQ8
        end
      end
    endcase
  end

  // =====================================================================
  // Register port and copy sequencer
  always @(posedge ref_clk) begin
    if (rst) begin
      state_ff   <= S_BOOT;
      cp_idx_ff  <= 4'h0;
      fix_on_ff  <= 1'b0;
      method_ff  <= `DPC_M_AVG;
      stg_cnt_ff <= 5'h00;
      act_cnt_ff <= 5'h00;
      sel_ff     <= 4'h0;
      rdata_ff   <= 32'h0000_0000;
    end else begin
      if (reg_wr && reg_addr == `DPC_A_CTRL) begin
        fix_on_ff <= reg_wdata[`DPC_CTRL_EN];
        method_ff <= reg_wdata[`DPC_CTRL_M_HI:`DPC_CTRL_M_LO];
      end
      if (idle && reg_wr && reg_addr == `DPC_A_COUNT) begin
        stg_cnt_ff <= clamp_cnt(reg_wdata); // RQ4 RQ8
      end
      if (idle && reg_wr && reg_addr == `DPC_A_SEL &&
          reg_wdata < {27'h000_0000, stg_cnt_ff}) begin
        sel_ff <= reg_wdata[3:0]; // RQ5
      end
      case (state_ff)
        S_IDLE: begin
          cp_idx_ff <= 4'h0;
          if (reg_wr && reg_addr == `DPC_A_CMD) begin
            if (reg_wdata[`DPC_CMD_FACT]) begin
              state_ff <= S_FACT;
            end else if (reg_wdata[`DPC_CMD_APPLY]) begin
              state_ff <= S_APPLY; // RQ8
            end else if (reg_wdata[`DPC_CMD_SAVE]) begin
              state_ff <= S_SAVE;
            end
          end
        end
        S_APPLY, S_SAVE, S_FACT, S_BOOT: begin
          cp_idx_ff <= cp_idx_ff + 4'h1;
          if (last) begin
            state_ff <= S_IDLE;
            if (state_ff == S_APPLY) begin
              act_cnt_ff <= stg_cnt_ff; // RQ9
            end
            if (state_ff == S_FACT) begin
              act_cnt_ff <= `DPC_FACT_CNT;
              stg_cnt_ff <= `DPC_FACT_CNT;
              sel_ff     <= 4'h0;
            end
            // Unknown mark at first power-up must pick the factory count
            if (state_ff == S_BOOT) begin
              if (boot_nvm) begin
                act_cnt_ff <= nvm_cnt_ff; // RQ10
                stg_cnt_ff <= nvm_cnt_ff;
              end else begin
                act_cnt_ff <= `DPC_FACT_CNT; // RQ13
                stg_cnt_ff <= `DPC_FACT_CNT;
              end
            end
          end
        end
        default: begin
          state_ff <= S_IDLE;
        end
      endcase
      rdata_ff <= 32'h0000_0000;
      if (reg_rd) begin
        case (reg_addr)
          `DPC_A_CTRL:    rdata_ff <= {29'h0000_0000, method_ff, fix_on_ff};
          `DPC_A_COUNT:   rdata_ff <= {27'h000_0000, stg_cnt_ff};
          `DPC_A_SEL:     rdata_ff <= {28'h000_0000, sel_ff};
          `DPC_A_COORD_X: rdata_ff <= {20'h0_0000, stg_x[sel_ff]}; // RQ17
          `DPC_A_COORD_Y: rdata_ff <= {20'h0_0000, stg_y[sel_ff]}; // RQ17
          `DPC_A_STATUS:  rdata_ff <= {19'h0_0000, act_cnt_ff, 7'h00, ~idle};
          default:        rdata_ff <= 32'h0000_0000;
        endcase
      end
    end
  end

  always @* begin
    reg_rdata = rdata_ff;
  end

  // =====================================================================
  // Input position tracking and defect lookup
  reg  [11:0] x_cnt_ff;
  reg  [11:0] y_cnt_ff;
  reg         line_open_ff;
  reg         hit;
  integer     i;
  integer     j;
  wire        take  = pix_valid & pix_ready;
  wire [11:0] cur_x = pix_sof ? 12'h000 : x_cnt_ff;
  wire [11:0] cur_y = pix_sof ? 12'h000 : y_cnt_ff;
  wire [11:0] frm_x = cur_x + roi_off_x; // RQ7
  wire [11:0] frm_y = cur_y + roi_off_y; // RQ7

  // Entries are updated one by one during a load
  always @* begin
    hit = 1'b0;
    for (i = 0; i < `DPC_ENTRIES; i = i + 1) begin
      if (i < act_cnt_ff && act_x[i] == frm_x && act_y[i] == frm_y) begin
        hit = 1'b1; // RQ14
      end
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      x_cnt_ff     <= 12'h000;
      y_cnt_ff     <= 12'h000;
      line_open_ff <= 1'b0;
    end else if (take) begin
      line_open_ff <= ~pix_eol;
      if (pix_eol) begin
        x_cnt_ff <= 12'h000;
        y_cnt_ff <= cur_y + 12'h001;
      end else begin
        x_cnt_ff <= cur_x + 12'h001;
        y_cnt_ff <= cur_y;
      end
    end
  end

  // =====================================================================
  // Five slot window, slot 2 is the pixel being corrected
  reg  [11:0] w_pix_ff [0:4];
  reg  [4:0]  w_vld_ff;
  reg  [4:0]  w_sof_ff;
  reg  [4:0]  w_eol_ff;
  reg  [4:0]  w_def_ff;
  reg  [4:0]  w_lok_ff;
  reg  [11:0] fixed;
  wire        fifo_in_ready;
  wire [3:0]  fifo_level;
  wire        flush = ~line_open_ff & (|w_vld_ff[2:0]) & fifo_in_ready;
  wire        adv   = take | flush;
  wire        push  = adv & w_vld_ff[2];
  wire        l_ok  = w_lok_ff[2] & w_vld_ff[4];
  wire        r_ok  = w_vld_ff[0] & w_vld_ff[1] & ~w_eol_ff[2] & ~w_eol_ff[1];
  wire [12:0] sum   = {1'b0, w_pix_ff[4]} + {1'b0, w_pix_ff[0]};

  always @* begin
    fixed = w_pix_ff[2];
    if (fix_on_ff && w_def_ff[2]) begin // RQ1
      case (method_ff)
        `DPC_M_HIGH: fixed = `DPC_PIX_MAX;  // RQ3
        `DPC_M_ZERO: fixed = `DPC_PIX_ZERO; // RQ15
        default: begin
          if (l_ok && r_ok) begin
            fixed = sum[12:1]; // RQ2 RQ16
          end else if (l_ok) begin
            fixed = w_pix_ff[4]; // RQ16
          end else if (r_ok) begin
            fixed = w_pix_ff[0]; // RQ16
          end
        end
      endcase
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      w_vld_ff  <= 5'h00;
      w_sof_ff  <= 5'h00;
      w_eol_ff  <= 5'h00;
      w_def_ff  <= 5'h00;
      w_lok_ff  <= 5'h00;
      pix_ready <= 1'b0;
      for (j = 0; j < 5; j = j + 1) begin
        w_pix_ff[j] <= 12'h000;
      end
    end else begin
      // Registered space check leaves one free word for the lag
      pix_ready <= (fifo_level <= `DPC_FIFO_HIWAT);
      if (adv) begin
        for (j = 4; j > 0; j = j - 1) begin
          w_pix_ff[j] <= w_pix_ff[j-1];
        end
        w_pix_ff[0] <= take ? pix_data : 12'h000;
        w_vld_ff    <= {w_vld_ff[3:0], take};
        w_sof_ff    <= {w_sof_ff[3:0], take & pix_sof};
        w_eol_ff    <= {w_eol_ff[3:0], take & pix_eol};
        w_def_ff    <= {w_def_ff[3:0], take & hit};
        w_lok_ff    <= {w_lok_ff[3:0], take & (cur_x >= 12'h002)}; // RQ16
      end
    end
  end

  // =====================================================================
  // Output buffer
  wire [13:0] fifo_out;

  pix_fifo #(
    .W     (`DPC_FIFO_W),
    .DEPTH (`DPC_FIFO_DEPTH),
    .AW    (`DPC_FIFO_AW)
  ) u_fifo (
    .clk       (ref_clk),
    .rst       (rst),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .in_data   ({w_sof_ff[2], w_eol_ff[2], fixed}),
    .level     (fifo_level),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (fifo_out)
  );

  assign out_sof  = fifo_out[13];
  assign out_eol  = fifo_out[12];
  assign out_data = fifo_out[11:0];
endmodule
`default_nettype wire

// ### include/dpc_regs.vh
// Register map, field positions and sizes of the defect pixel corrector.
// Assumes inclusion by bare name from the rtl files.
`ifndef DPC_REGS_VH
`define DPC_REGS_VH

`define DPC_ENTRIES     16
`define DPC_LAST_IDX    4'hF
`define DPC_IDX_W       4
`define DPC_CNT_W       5
`define DPC_COORD_W     12
`define DPC_PIX_W       12
`define DPC_PIX_MAX     12'h0FFF
`define DPC_PIX_ZERO    12'h0000

`define DPC_A_CTRL      8'h00
`define DPC_A_COUNT     8'h04
`define DPC_A_SEL       8'h08
`define DPC_A_COORD_X   8'h0C
`define DPC_A_COORD_Y   8'h10
`define DPC_A_CMD       8'h14
`define DPC_A_STATUS    8'h18

`define DPC_CTRL_EN     0
`define DPC_CTRL_M_LO   1
`define DPC_CTRL_M_HI   2
`define DPC_M_AVG       2'h0
`define DPC_M_HIGH      2'h1
`define DPC_M_ZERO      2'h2

`define DPC_CMD_APPLY   0
`define DPC_CMD_SAVE    1
`define DPC_CMD_FACT    2

`define DPC_ST_BUSY     0
`define DPC_ST_ACNT_LO  8
`define DPC_ST_ACNT_HI  12

`define DPC_NVM_MARK    16'hA5C3
`define DPC_FACT_CNT    5'h04

`define DPC_FIFO_W      14
`define DPC_FIFO_DEPTH  8
`define DPC_FIFO_AW     3
`define DPC_FIFO_HIWAT  4'h6

`endif

// ### tb/dpc_properties.sv
// Port-level checks of the defect pixel corrector.
// Assumes one clock domain and binding onto the top module.
`timescale 1ns/1ns
`default_nettype none
`include "dpc_regs.vh"
// ==========
// Checker
module dpc_properties (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        rst,
  // Register port
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  // Streams
  input wire logic        pix_ready,
  input wire logic        out_valid,
  input wire logic        out_ready,
  input wire logic [11:0] out_data,
  input wire logic        out_sof,
  input wire logic        out_eol
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  property p_rst_quiet;
    disable iff (1'b0) rst |=> !out_valid && !pix_ready && reg_rdata == 32'h0000_0000;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("outputs active in reset");
  property p_rd_zero;
    !$past(reg_rd) |-> reg_rdata == 32'h0000_0000;
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("read data outside read slot");
  property p_ready_boot;
    $fell(rst) |=> pix_ready;
  endproperty
  a_ready_boot: assert property (p_ready_boot) else $error("input not ready after reset");
  property p_stall;
    out_valid && !out_ready |=> out_valid && $stable({out_data, out_sof, out_eol});
  endproperty
  a_stall: assert property (p_stall) else $error("output word changed while stalled");
  property p_unmapped;
    reg_rd && reg_addr == 8'h20 |=> reg_rdata == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_status;
    reg_rd && reg_addr == `DPC_A_STATUS |=> reg_rdata[31:13] == 0 && reg_rdata[12:8] <= 5'h10;
  endproperty
  a_status: assert property (p_status) else $error("status layout wrong");
  property p_coord;
    reg_rd && (reg_addr == `DPC_A_COORD_X || reg_addr == `DPC_A_COORD_Y) |=> reg_rdata[31:12] == 0;
  endproperty
  a_coord: assert property (p_coord) else $error("coordinate too wide");
  property p_ctrl_rb;
    reg_wr && reg_addr == `DPC_A_CTRL ##1 reg_rd && reg_addr == `DPC_A_CTRL
      |=> ((reg_rdata ^ $past(reg_wdata, 2)) & 32'h0000_0007) == 32'h0000_0000;
  endproperty
  a_ctrl_rb: assert property (p_ctrl_rb) else $error("control readback wrong");
  property p_busy;
    reg_wr && reg_addr == `DPC_A_CMD && reg_wdata[0] ##1 reg_rd && reg_addr == `DPC_A_STATUS
      |=> reg_rdata[0];
  endproperty
  a_busy: assert property (p_busy) else $error("apply did not start a load");
  property p_boot;
    $fell(rst) && reg_rd && reg_addr == `DPC_A_STATUS |=> reg_rdata[0];
  endproperty
  a_boot: assert property (p_boot) else $error("no boot load after reset");
endmodule
bind defective_pixel_corrector dpc_properties u_dpc_props (
  .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pix_ready(pix_ready),
  .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
  .out_sof(out_sof), .out_eol(out_eol));
`default_nettype wire

// ### tb/sensor_model.sv
// Sensor stand-in sending one line of LINE pixels per start pulse.
// Assumes valid/ready input of the corrector on ref_clk.
`timescale 1ns/1ns
`default_nettype none
// ==========
// Pixel source
module sensor_model #(
  parameter LINE = 16
) (
  // Clock, reset, control
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        start,
  input wire logic        slow,
  input wire logic [11:0] base,
  // Stream
  input wire logic        pix_ready,
  output logic            pix_valid,
  output logic [11:0]     pix_data,
  output logic            pix_sof,
  output logic            pix_eol,
  output logic            busy
);
  logic [4:0] x_ff;
  logic       gap_ff;
  always @(posedge ref_clk) begin
    if (rst) begin
      pix_valid <= 1'b0;
      pix_data  <= 12'h000;
      pix_sof   <= 1'b0;
      pix_eol   <= 1'b0;
      busy      <= 1'b0;
      x_ff      <= 5'h00;
      gap_ff    <= 1'b0;
    end else if (!pix_valid || pix_ready) begin
      if (busy && !gap_ff && x_ff != LINE) begin
        pix_valid <= 1'b1;
        pix_data  <= base + x_ff * x_ff * 12'h004;
        pix_sof   <= x_ff == 0;
        pix_eol   <= x_ff == LINE - 1;
        x_ff      <= x_ff + 5'h01;
        gap_ff    <= slow;
      end else begin
        // Released data lines toggle every cycle; sof and eol stay low
        pix_valid <= 1'b0;
        pix_data  <= ~pix_data;
        pix_sof   <= 1'b0;
        pix_eol   <= 1'b0;
        gap_ff    <= 1'b0;
        busy      <= busy ? x_ff != LINE : start;
        if (!busy) x_ff <= 5'h00;
      end
    end
  end
endmodule
`default_nettype wire

// ### tb/defective_pixel_corrector_tb.sv
// Self-checking bench of the defect pixel corrector.
// Assumes the sensor model on the input and a random stalling sink.
`timescale 1ns/1ns
`default_nettype none
`include "dpc_regs.vh"
// ==========
// Bench
module defective_pixel_corrector_tb;
  logic        ref_clk = 1'b0;
  logic        rst, reg_wr, reg_rd, start, slow, hold, out_ready, rd_d;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [11:0] roi_off_x, roi_off_y, base, pix_data, out_data;
  logic        pix_valid, pix_ready, pix_sof, pix_eol, out_valid, out_sof, out_eol, s_busy;
  logic [13:0] pq[$];
  logic [63:0] rq[$];
  integer      seed = 70998;
  integer      n_mismatch = 0;
  integer      n_checks = 0;
  integer      m;
  always #10 ref_clk = ~ref_clk;
  defective_pixel_corrector dut (
    .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .roi_off_x(roi_off_x),
    .roi_off_y(roi_off_y), .pix_valid(pix_valid), .pix_ready(pix_ready),
    .pix_data(pix_data), .pix_sof(pix_sof), .pix_eol(pix_eol), .out_valid(out_valid),
    .out_ready(out_ready), .out_data(out_data), .out_sof(out_sof), .out_eol(out_eol));
  sensor_model #(.LINE(16)) u_src (
    .ref_clk(ref_clk), .rst(rst), .start(start), .slow(slow), .base(base),
    .pix_ready(pix_ready), .pix_valid(pix_valid), .pix_data(pix_data),
    .pix_sof(pix_sof), .pix_eol(pix_eol), .busy(s_busy));
  function [11:0] pv(input [11:0] b, input [4:0] x);
    pv = b + x * x * 12'h004;
  endfunction
  task chk_reg(input [63:0] e, input [31:0] g);
    n_checks = n_checks + 1;
    if (((g ^ e[31:0]) & e[63:32]) !== 32'h0000_0000) begin
      n_mismatch = n_mismatch + 1;
      $display("CHECK FAILED at %0t: register read %h", $time, g);
    end
  endtask
  task chk_pix(input [13:0] e, input [13:0] g);
    n_checks = n_checks + 1;
    if (g !== e) begin
      n_mismatch = n_mismatch + 1;
      $display("CHECK FAILED at %0t: pixel %h expected %h", $time, g, e);
    end
  endtask
  // Result watcher
  always @(posedge ref_clk) begin
    rd_d <= reg_rd;
    if (rd_d) chk_reg(rq.pop_front(), reg_rdata);
    if (out_valid && out_ready) chk_pix(pq.pop_front(), {out_sof, out_eol, out_data});
  end
  always @(posedge ref_clk) begin
    slow      <= $random(seed);
    out_ready <= !hold && ($random(seed) % 4 != 0);
  end
  task op(input w, input [7:0] a, input [31:0] d, input [31:0] k);
    reg_wr    <= w;
    reg_rd    <= !w;
    reg_addr  <= a;
    reg_wdata <= d;
    if (!w) rq.push_back({k, d});
    @(posedge ref_clk);
  endtask
  task idle(input integer n);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    repeat (n) @(posedge ref_clk);
  endtask
  task power_cycle;
    rst <= 1'b1;
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    op(0, `DPC_A_STATUS, 32'h0000_0001, 32'h0000_0001);
    idle(18);
  endtask
  task frame(input [2:0] c, input [15:0] k, input h);
    logic [11:0] b, e;
    integer      x;
    op(1, `DPC_A_CTRL, c, 0);
    op(0, `DPC_A_CTRL, c, 32'h0000_0007);
    idle(1);
    b = $random(seed) & 12'h3FF;
    for (x = 0; x < 16; x++) begin
      e = pv(b, x);
      if (c[0] && k[x])
        e = c[2:1] == `DPC_M_HIGH ? `DPC_PIX_MAX : c[2:1] == `DPC_M_ZERO ? `DPC_PIX_ZERO
          : (pv(b, x - 2) + pv(b, x + 2)) >> 1;
      pq.push_back({x == 0, x == 15, e});
    end
    base  <= b;
    hold  <= h;
    start <= 1'b1;
    @(posedge ref_clk);
    start <= 1'b0;
    // Held sink fills the buffer until input is refused
    repeat (h ? 40 : 1) @(posedge ref_clk);
    if (h) chk_reg({32'h0000_0001, 32'h0000_0000}, {31'h0, pix_ready});
    hold <= 1'b0;
    for (x = 0; x < 400 && (s_busy || pq.size() > 0); x++) @(posedge ref_clk);
    // A frame that never drains counts as a mismatch
    if (s_busy || pq.size() > 0) begin
      n_mismatch = n_mismatch + 1;
      $display("CHECK FAILED at %0t: frame did not drain", $time);
    end
  endtask
  task tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (6000) @(posedge ref_clk);
    n_mismatch = n_mismatch + 1;
    tally_and_finish;
  end
  initial begin
    rst = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00; reg_wdata = 0;
    start = 1'b0; slow = 1'b0; hold = 1'b0; out_ready = 1'b0; base = 12'h000;
    roi_off_x = 12'h060;
    roi_off_y = 12'h032;
    power_cycle;
    op(0, `DPC_A_STATUS, 32'h0000_0400, 32'hFFFF_FFFF);
    op(0, `DPC_A_COORD_X, 32'h0000_0064, 32'hFFFF_FFFF);
    op(0, `DPC_A_COORD_Y, 32'h0000_0032, 32'hFFFF_FFFF);
    op(0, 8'h20, 0, 32'hFFFF_FFFF);
    idle(1);
    frame(3'h0, 16'h0010, 0);
    for (m = 0; m < 4; m++) frame({m[1:0], 1'b1}, 16'h0010, 0);
    op(1, `DPC_A_COUNT, 32'h0000_0005, 0);
    op(1, `DPC_A_SEL, 32'h0000_0004, 0);
    op(1, `DPC_A_COORD_X, 32'h0000_006C, 0);
    op(1, `DPC_A_COORD_Y, 32'h0000_0032, 0);
    op(1, `DPC_A_SEL, 32'h0000_0005, 0);
    op(0, `DPC_A_SEL, 32'h0000_0004, 32'hFFFF_FFFF);
    op(0, `DPC_A_COORD_X, 32'h0000_006C, 32'hFFFF_FFFF);
    idle(1);
    frame(3'h1, 16'h0010, 0);
    op(1, `DPC_A_CMD, 32'h0000_0001, 0);
    op(0, `DPC_A_STATUS, 32'h0000_0401, 32'hFFFF_FFFF);
    idle(18);
    op(0, `DPC_A_STATUS, 32'h0000_0500, 32'hFFFF_FFFF);
    idle(1);
    frame(3'h3, 16'h1010, 1);
    op(1, `DPC_A_CMD, 32'h0000_0002, 0);
    idle(18);
    power_cycle;
    op(0, `DPC_A_STATUS, 32'h0000_0500, 32'hFFFF_FFFF);
    op(1, `DPC_A_CMD, 32'h0000_0004, 0);
    idle(18);
    op(0, `DPC_A_STATUS, 32'h0000_0400, 32'hFFFF_FFFF);
    op(0, `DPC_A_COORD_X, 32'h0000_0064, 32'hFFFF_FFFF);
    idle(1);
    power_cycle;
    op(0, `DPC_A_STATUS, 32'h0000_0400, 32'hFFFF_FFFF);
    idle(1);
    frame(3'h1, 16'h0010, 0);
    tally_and_finish;
  end
endmodule
`default_nettype wire
